// ==== hw/eps_pkg.sv ====
/*
  Shared constants for the page programming sequencer pair.
  Assumes one 200 MHz clock and a synchronous active-high reset on both ends.
*/
// Summary of operation
// R1 - Main and sub keep separate 3-bit selectors
// R2 - Selector codes: off, equal spacing, versions A-D
// R3 - Activation accepted only inside power-on window
// R4 - Page select loads page into working lines
// R5 - Programmer writes lines after page select
// R6 - Pulse of 400 ms burns lines into page
// R7 - Pulse starts within 20 ms of frame
// R8 - Programmer pauses after every pulse
// R9 - Programmer repeats sequence per page
// R10 - At most 10 programming cycles per page
// R11 - Status shows programming routine finished correctly
// R12 - Programmer reads back every line afterwards
// R13 - Margin command plus 7 ms pulse runs check
// R14 - Lock command plus 135 ms pulse locks
// R15 - Pages 0 and 1 lockable, rest locked
// R16 - Locked memory refuses all later rewrites
// R17 - Status shows lock state
// R18 - Exit command returns device to normal
// R19 - Margin start delay 8 bits, 32 us steps
// R20 - Locked page program leaves content and status; code sets ST_REFUSE in status
package eps_pkg;
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned PROG_MS        = 400;
  localparam int unsigned MARGIN_MS      = 7;
  localparam int unsigned LOCK_MS        = 135;
  localparam int unsigned START_WIN_MS   = 20;
  localparam int unsigned PAUSE_MS       = 1;
  localparam int unsigned ACT_WIN_MS     = 10;
  localparam int unsigned DLY_STEP_US    = 32;
  localparam int unsigned PROG_CYC   = PROG_MS * 1000 * CLK_MHZ;
  localparam int unsigned MARGIN_CYC = MARGIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned LOCK_CYC   = LOCK_MS * 1000 * CLK_MHZ;
  localparam int unsigned START_CYC  = START_WIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned PAUSE_CYC  = PAUSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned ACT_CYC    = ACT_WIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned STEP_CYC   = DLY_STEP_US * CLK_MHZ;
  localparam int unsigned MAX_CYCLES = 10;
  localparam int unsigned PAGES      = 4;
  localparam int unsigned LINES      = 4;
  localparam int unsigned LW         = 16;
  localparam logic [1:0]  LOCK_PAGES = 2'h1;
  // Selector codes
  localparam logic [2:0] LIN_OFF   = 3'h0;
  localparam logic [2:0] LIN_EQUAL = 3'h1;
  localparam logic [2:0] LIN_VER_D = 3'h5;
  // Field placement of selectors in page 0, line 0
  localparam int unsigned LIN_MAIN_LSB = 0;
  localparam int unsigned LIN_SUB_LSB  = 3;
  // Status bits
  localparam int unsigned ST_OK     = 0;
  localparam int unsigned ST_LOCK   = 1;
  localparam int unsigned ST_MARGIN = 2;
  localparam int unsigned ST_REFUSE = 3;
  localparam logic [7:0]  ST_RESET  = 8'h00;
  typedef enum logic [2:0] {
    EPS_CMD_ACT, EPS_CMD_SELECT, EPS_CMD_WRITE, EPS_CMD_PROG,
    EPS_CMD_MARGIN, EPS_CMD_LOCK, EPS_CMD_EXIT, EPS_CMD_READ
  } eps_cmd_t;
endpackage

// ==== hw/eps_if.sv ====
/*
  Link between programmer and sensor: one command frame strobe with
  fields, a programming pulse level and a read-back answer.
  Assumes both ends share i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface eps_if;
  logic                    frame_vld;
  eps_pkg::eps_cmd_t       frame_cmd;
  logic [7:0]              frame_arg;
  logic [eps_pkg::LW-1:0]  frame_data;
  logic                    prog_pulse;
  logic                    rd_vld;
  logic [eps_pkg::LW-1:0]  rd_data;
  modport dev (input frame_vld, frame_cmd, frame_arg, frame_data,
               prog_pulse, output rd_vld, rd_data);
  modport prg (output frame_vld, frame_cmd, frame_arg, frame_data,
               prog_pulse, input rd_vld, rd_data);
endinterface
`default_nettype wire

// ==== hw/eps_device.sv ====
/*
  Sensor end: programming mode, working lines, page burn, margin
  check and customer lock.
  Assumes frames arrive as single-cycle strobes synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module eps_device #(
  parameter int unsigned PROG_CYC   = eps_pkg::PROG_CYC,
  parameter int unsigned MARGIN_CYC = eps_pkg::MARGIN_CYC,
  parameter int unsigned LOCK_CYC   = eps_pkg::LOCK_CYC,
  parameter int unsigned ACT_CYC    = eps_pkg::ACT_CYC,
  parameter int unsigned STEP_CYC   = eps_pkg::STEP_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  eps_if.dev              link,
  output logic            o_prog_mode,
  output logic [2:0]      o_lin_select_main,
  output logic [2:0]      o_lin_select_sub,
  output logic [7:0]      o_nvm_status_reg
);
  localparam int unsigned LW = eps_pkg::LW;
  localparam int unsigned LN = eps_pkg::LINES;
  localparam int unsigned PG = eps_pkg::PAGES;

  typedef enum logic [2:0] {
    EPS_OFF, EPS_IDLE, EPS_ARMED, EPS_BURN, EPS_MDELAY, EPS_DONE
  } eps_state_t;

  // ****************************************
  // Storage
  // ****************************************
  logic [LW-1:0] nvm_reg  [PG][LN];
  logic [LW-1:0] work_reg [LN];
  logic [1:0]    page_reg;
  logic [1:0]    arm_kind_reg;
  eps_state_t    state_reg;
  logic [31:0]   cnt_reg;
  logic [31:0]   act_cnt_reg;
  logic [31:0]   dly_reg;
  logic [7:0]    status_reg;
  logic          cust_lock_reg;
  logic          rd_vld_reg;
  logic [LW-1:0] rd_data_reg;

  wire frame = link.frame_vld;
  wire [1:0] sel_page = link.frame_arg[1:0];
  wire [1:0] sel_line = link.frame_arg[3:2];
  // Lock applies to pages 0-1; others locked from delivery [R15]
  wire page_locked = cust_lock_reg || (page_reg > eps_pkg::LOCK_PAGES);
  wire [31:0] burn_len = (arm_kind_reg == 2'h0) ? PROG_CYC :
                         (arm_kind_reg == 2'h1) ? MARGIN_CYC : LOCK_CYC;

  // ****************************************
  // Activation window
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      act_cnt_reg <= 32'h0;
    else if (act_cnt_reg < ACT_CYC)
      act_cnt_reg <= act_cnt_reg + 32'h1;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg    <= EPS_OFF;
      cnt_reg      <= 32'h0;
      dly_reg      <= 32'h0;
      page_reg     <= 2'h0;
      arm_kind_reg <= 2'h0;
      status_reg   <= eps_pkg::ST_RESET;
      cust_lock_reg <= 1'b0;
      rd_vld_reg   <= 1'b0;
      rd_data_reg  <= '0;
      for (int p = 0; p < PG; p++)
      begin
        for (int l = 0; l < LN; l++)
          nvm_reg[p][l] <= '0;
      end
      for (int l = 0; l < LN; l++)
        work_reg[l] <= '0;
    end
    else
    begin
      rd_vld_reg <= 1'b0;
      case (state_reg)
        EPS_OFF:
          if (frame && link.frame_cmd == eps_pkg::EPS_CMD_ACT
              && act_cnt_reg < ACT_CYC)                          // [R3]
            state_reg <= EPS_IDLE;
        EPS_IDLE, EPS_DONE:
        begin
          if (state_reg == EPS_DONE && !link.prog_pulse)
            state_reg <= EPS_IDLE;
          if (frame && state_reg == EPS_IDLE)
            case (link.frame_cmd)
              eps_pkg::EPS_CMD_SELECT:
              begin
                page_reg <= sel_page;
                for (int l = 0; l < LN; l++)
                  work_reg[l] <= nvm_reg[sel_page][l];           // [R4]
              end
              eps_pkg::EPS_CMD_WRITE:
                work_reg[sel_line] <= link.frame_data;
              eps_pkg::EPS_CMD_READ:
              begin
                rd_vld_reg  <= 1'b1;
                rd_data_reg <= (link.frame_arg[7]) ?
                  {8'h00, status_reg} : nvm_reg[page_reg][sel_line];
              end
              eps_pkg::EPS_CMD_PROG:
              begin
                arm_kind_reg <= 2'h0;
                state_reg    <= EPS_ARMED;
              end
              eps_pkg::EPS_CMD_MARGIN:
              begin
                arm_kind_reg <= 2'h1;
                // Start delay in 32 us steps [R19]
                dly_reg   <= 32'(link.frame_arg) * STEP_CYC;
                state_reg <= EPS_ARMED;
              end
              eps_pkg::EPS_CMD_LOCK:
              begin
                arm_kind_reg <= 2'h2;
                state_reg    <= EPS_ARMED;
              end
              eps_pkg::EPS_CMD_EXIT:
                state_reg <= EPS_OFF;                            // [R18]
              default: ;
            endcase
          cnt_reg <= 32'h0;
        end
        EPS_ARMED:
          if (link.prog_pulse)
            state_reg <= (arm_kind_reg == 2'h1 && dly_reg != 0) ?
                         EPS_MDELAY : EPS_BURN;
        EPS_MDELAY:
          if (!link.prog_pulse)
            state_reg <= EPS_DONE;
          else if (cnt_reg + 32'h1 >= dly_reg)
          begin
            cnt_reg   <= 32'h0;
            state_reg <= EPS_BURN;
          end
          else
            cnt_reg <= cnt_reg + 32'h1;
        EPS_BURN:
          if (!link.prog_pulse)
          begin
            // Short pulse: routine not finished
            if (arm_kind_reg == 2'h0)
              status_reg[eps_pkg::ST_OK] <= page_locked ?
                status_reg[eps_pkg::ST_OK] : 1'b0;               // [R20]
            state_reg <= EPS_DONE;
          end
          else if (cnt_reg + 32'h1 >= burn_len)
          begin
            state_reg <= EPS_DONE;
            case (arm_kind_reg)
              2'h0:
                if (page_locked)
                  status_reg[eps_pkg::ST_REFUSE] <= 1'b1;        // [R16] [R20]
                else
                begin
                  for (int l = 0; l < LN; l++)
                    nvm_reg[page_reg][l] <= work_reg[l];         // [R6]
                  status_reg[eps_pkg::ST_OK] <= 1'b1;            // [R11]
                end
              2'h1:
                status_reg[eps_pkg::ST_MARGIN] <= 1'b1;          // [R13]
              default:
              begin
                cust_lock_reg <= 1'b1;                           // [R14]
                status_reg[eps_pkg::ST_LOCK] <= 1'b1;            // [R17]
              end
            endcase
          end
          else
            cnt_reg <= cnt_reg + 32'h1;
        default:
          state_reg <= EPS_OFF;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_prog_mode       <= 1'b0;
      o_lin_select_main <= eps_pkg::LIN_OFF;
      o_lin_select_sub  <= eps_pkg::LIN_OFF;
      o_nvm_status_reg  <= eps_pkg::ST_RESET;
    end
    else
    begin
      o_prog_mode <= (state_reg != EPS_OFF);
      // Separate selectors from nonvolatile page 0 [R1] [R2]
      o_lin_select_main <= nvm_reg[0][0][eps_pkg::LIN_MAIN_LSB +: 3];
      o_lin_select_sub  <= nvm_reg[0][0][eps_pkg::LIN_SUB_LSB +: 3];
      o_nvm_status_reg  <= status_reg;
    end
  end

  assign link.rd_vld  = rd_vld_reg;
  assign link.rd_data = rd_data_reg;
endmodule
`default_nettype wire

// ==== hw/eps_programmer.sv ====
/*
  Programmer end: turns user requests into frames and drives the
  programming pulse with start delay, length and pause.
  Assumes one request at a time; i_busy-free handshake via o_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module eps_programmer #(
  parameter int unsigned PROG_CYC   = eps_pkg::PROG_CYC,
  parameter int unsigned MARGIN_CYC = eps_pkg::MARGIN_CYC,
  parameter int unsigned LOCK_CYC   = eps_pkg::LOCK_CYC,
  parameter int unsigned PAUSE_CYC  = eps_pkg::PAUSE_CYC,
  parameter int unsigned STEP_CYC   = eps_pkg::STEP_CYC,
  parameter int unsigned LEAD_CYC   = 16
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_req,
  input  wire eps_pkg::eps_cmd_t      i_cmd,
  input  wire logic [7:0]             i_arg,
  input  wire logic [eps_pkg::LW-1:0] i_data,
  output logic                        o_ready,
  output logic                        o_rd_vld,
  output logic [eps_pkg::LW-1:0]      o_rd_data,
  output logic                        o_refused,
  eps_if.prg                          link
);
  typedef enum logic [2:0] {
    EPP_IDLE, EPP_LEAD, EPP_PULSE, EPP_PAUSE
  } epp_state_t;

  epp_state_t        state_reg;
  logic [31:0]       cnt_reg;
  logic [31:0]       len_reg;
  logic              vld_reg;
  eps_pkg::eps_cmd_t cmd_reg;
  logic [7:0]        arg_reg;
  logic [eps_pkg::LW-1:0] data_reg;
  logic              pulse_reg;
  logic [3:0]        cyc_reg [eps_pkg::PAGES];
  logic [1:0]        page_reg;

  wire burns = (i_cmd == eps_pkg::EPS_CMD_PROG) ||
               (i_cmd == eps_pkg::EPS_CMD_MARGIN) ||
               (i_cmd == eps_pkg::EPS_CMD_LOCK);
  // Cycle budget per page exhausted [R10]
  wire over = (i_cmd == eps_pkg::EPS_CMD_PROG) &&
              (cyc_reg[page_reg] >= 4'(eps_pkg::MAX_CYCLES));

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= EPP_IDLE;
      cnt_reg   <= 32'h0;
      len_reg   <= 32'h0;
      vld_reg   <= 1'b0;
      cmd_reg   <= eps_pkg::EPS_CMD_ACT;
      arg_reg   <= 8'h00;
      data_reg  <= '0;
      pulse_reg <= 1'b0;
      page_reg  <= 2'h0;
      o_ready   <= 1'b0;
      o_refused <= 1'b0;
      for (int p = 0; p < eps_pkg::PAGES; p++)
        cyc_reg[p] <= 4'h0;
    end
    else
    begin
      vld_reg   <= 1'b0;
      o_refused <= 1'b0;
      case (state_reg)
        EPP_IDLE:
        begin
          o_ready <= 1'b1;
          if (i_req && o_ready)
          begin
            o_ready <= 1'b0;
            if (over)
              o_refused <= 1'b1;                                  // [R10]
            else
            begin
              vld_reg  <= 1'b1;
              cmd_reg  <= i_cmd;
              arg_reg  <= i_arg;
              data_reg <= i_data;
              if (i_cmd == eps_pkg::EPS_CMD_SELECT)
                page_reg <= i_arg[1:0];                           // [R9]
              if (i_cmd == eps_pkg::EPS_CMD_PROG)
                cyc_reg[page_reg] <= cyc_reg[page_reg] + 4'h1;
              len_reg <= (i_cmd == eps_pkg::EPS_CMD_PROG) ? PROG_CYC :  // [R6]
                         (i_cmd == eps_pkg::EPS_CMD_MARGIN) ?
                           MARGIN_CYC + 32'(i_arg) * STEP_CYC :   // [R13]
                         LOCK_CYC;                                // [R14]
              cnt_reg <= 32'h0;
              if (burns)
                state_reg <= EPP_LEAD;
            end
          end
        end
        EPP_LEAD:
          // Lead well inside start window [R7]
          if (cnt_reg + 32'h1 >= LEAD_CYC)
          begin
            cnt_reg   <= 32'h0;
            pulse_reg <= 1'b1;
            state_reg <= EPP_PULSE;
          end
          else
            cnt_reg <= cnt_reg + 32'h1;
        EPP_PULSE:
          // Two extra cycles cover device sampling lag
          if (cnt_reg >= len_reg + 32'h1)
          begin
            cnt_reg   <= 32'h0;
            pulse_reg <= 1'b0;
            state_reg <= EPP_PAUSE;
          end
          else
            cnt_reg <= cnt_reg + 32'h1;
        EPP_PAUSE:
          if (cnt_reg + 32'h1 >= PAUSE_CYC)                       // [R8]
            state_reg <= EPP_IDLE;
          else
            cnt_reg <= cnt_reg + 32'h1;
        default:
          state_reg <= EPP_IDLE;
      endcase
    end
  end

  // ****************************************
  // Read-back capture
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_rd_vld  <= 1'b0;
      o_rd_data <= '0;
    end
    else
    begin
      o_rd_vld <= link.rd_vld;                                    // [R12]
      if (link.rd_vld)
        o_rd_data <= link.rd_data;
    end
  end

  assign link.frame_vld  = vld_reg;                               // [R3] [R5]
  assign link.frame_cmd  = cmd_reg;
  assign link.frame_arg  = arg_reg;
  assign link.frame_data = data_reg;
  assign link.prog_pulse = pulse_reg;
endmodule
`default_nettype wire

// ==== test/eps_assertions.sv ====
/*
  Concurrent checks on the link between the two ends.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module eps_assertions #(
  parameter int unsigned MARGIN_CYC = 50
) (
  input wire logic              i_ref_clk,
  input wire logic              i_sys_rst,
  input wire logic              frame_vld,
  input wire eps_pkg::eps_cmd_t frame_cmd,
  input wire logic              prog_pulse,
  input wire logic              rd_vld,
  input wire logic              o_prog_mode,
  input wire logic [7:0]        o_nvm_status_reg
);
  // ****************
  // Pulse, read, mode and status checks
  // ****************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Counts cycles of high pulse; shortest legal one is margin
  int unsigned len_reg;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || !prog_pulse)
      len_reg <= 0;
    else
      len_reg <= len_reg + 1;
  end
  sequence s_burn_cmd;
    frame_vld && (frame_cmd inside {eps_pkg::EPS_CMD_PROG,
      eps_pkg::EPS_CMD_MARGIN, eps_pkg::EPS_CMD_LOCK});
  endsequence
  sequence s_pulse_up;
    ##[1:100] prog_pulse;
  endsequence
  sequence s_read_cmd;
    frame_vld && frame_cmd == eps_pkg::EPS_CMD_READ && o_prog_mode;
  endsequence
  chk_pulse_start: assert property (s_burn_cmd |-> s_pulse_up)
    else $error("pulse did not follow burn command");
  chk_pulse_len: assert property ($fell(prog_pulse) |->
    len_reg >= MARGIN_CYC) else $error("pulse too short");
  chk_pulse_pause: assert property ($fell(prog_pulse) |->
    !frame_vld [*8]) else $error("frame inside pause");
  chk_read_answer: assert property (s_read_cmd |=> rd_vld)
    else $error("read not answered");
  chk_read_single: assert property (rd_vld |=> !rd_vld)
    else $error("read answer too long");
  chk_read_cause: assert property (rd_vld |-> $past(frame_vld)
    && $past(frame_cmd) == eps_pkg::EPS_CMD_READ)
    else $error("read answer without request");
  chk_mode_entry: assert property ($rose(o_prog_mode) |->
    ($past(frame_vld) && $past(frame_cmd) == eps_pkg::EPS_CMD_ACT) ||
    ($past(frame_vld, 2) && $past(frame_cmd, 2) == eps_pkg::EPS_CMD_ACT))
    else $error("mode entered without activation");
  chk_lock_sticky: assert property (o_nvm_status_reg[1] |=>
    o_nvm_status_reg[1]) else $error("lock flag dropped");
  chk_refuse_ok: assert property ($rose(o_nvm_status_reg[3]) |->
    $stable(o_nvm_status_reg[0])) else $error("refusal moved ok flag");
endmodule
`default_nettype wire

// ==== test/tb.sv ====
/*
  Self-checking bench: programmer end drives device end over the link.
  Assumes shortened counts and one 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic              i_ref_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic              i_req     = 1'b0;
  eps_pkg::eps_cmd_t i_cmd     = eps_pkg::EPS_CMD_ACT;
  logic [7:0]        i_arg     = 8'h00;
  logic [15:0]       i_data    = 16'h0000;
  logic              o_ready, o_rd_vld, o_refused, o_prog_mode;
  logic [15:0]       o_rd_data;
  logic [2:0]        lin_m, lin_s;
  logic [7:0]        st;
  logic              ref_seen  = 1'b0;
  int                n_mismatch = 0;
  int                total_checks = 0;
  // Shortened counts keep the run small
  localparam int unsigned T_PROG   = 200;
  localparam int unsigned T_MARGIN = 50;
  localparam int unsigned T_LOCK   = 100;
  localparam int unsigned T_ACT    = 2000;
  localparam int unsigned T_STEP   = 2;
  localparam int unsigned T_PAUSE  = 10;
  localparam int unsigned T_LEAD   = 4;
  localparam logic [15:0] ST_ALL   = 16'((1 << eps_pkg::ST_OK) |
    (1 << eps_pkg::ST_LOCK) | (1 << eps_pkg::ST_MARGIN) |
    (1 << eps_pkg::ST_REFUSE));
  eps_if u_eps_if ();
  eps_device #(.PROG_CYC(T_PROG), .MARGIN_CYC(T_MARGIN),
    .LOCK_CYC(T_LOCK), .ACT_CYC(T_ACT), .STEP_CYC(T_STEP))
    u_eps_device (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .link(u_eps_if), .o_prog_mode(o_prog_mode),
    .o_lin_select_main(lin_m), .o_lin_select_sub(lin_s),
    .o_nvm_status_reg(st));
  eps_programmer #(.PROG_CYC(T_PROG), .MARGIN_CYC(T_MARGIN),
    .LOCK_CYC(T_LOCK), .PAUSE_CYC(T_PAUSE), .STEP_CYC(T_STEP),
    .LEAD_CYC(T_LEAD)) u_eps_programmer (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .i_req(i_req), .i_cmd(i_cmd), .i_arg(i_arg),
    .i_data(i_data), .o_ready(o_ready), .o_rd_vld(o_rd_vld),
    .o_rd_data(o_rd_data), .o_refused(o_refused), .link(u_eps_if));
  eps_assertions #(.MARGIN_CYC(T_MARGIN)) u_eps_assertions (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .frame_vld(u_eps_if.frame_vld), .frame_cmd(u_eps_if.frame_cmd),
    .prog_pulse(u_eps_if.prog_pulse), .rd_vld(u_eps_if.rd_vld),
    .o_prog_mode(o_prog_mode), .o_nvm_status_reg(st));
  always #2.5 i_ref_clk = ~i_ref_clk;
  // Refusal is a one-cycle pulse, so it is caught here
  always @(posedge i_ref_clk)
    if (o_refused === 1'b1)
      ref_seen <= 1'b1;
  // ****************
  // Shared tasks
  // ****************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input bit rd);
    for (int k = 0; k < 3000; k++)
    begin
      @(negedge i_ref_clk);
      if ((rd ? o_rd_vld : o_ready) === 1'b1)
        return;
    end
    n_mismatch++;
    $display("[ERR] t=%0t wait got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim;
  endtask
  task automatic req(input eps_pkg::eps_cmd_t c, input logic [7:0] a,
                     input logic [15:0] d);
    wait_for(0);
    @(posedge i_ref_clk);
    i_req <= 1'b1;
    i_cmd <= c;
    i_arg <= a;
    i_data <= d;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] l, input logic [15:0] exp);
    req(eps_pkg::EPS_CMD_READ, {4'h0, l, 2'h0}, 16'h0000);
    wait_for(1);
    cmp(o_rd_data, exp);
  endtask
  task automatic do_reset;
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
  endtask
  task automatic mode_is(input logic exp);
    wait_for(0);
    repeat (3) @(negedge i_ref_clk);
    cmp({15'h0, o_prog_mode}, {15'h0, exp});
  endtask
  function automatic logic [15:0] pat(input logic [1:0] p, l);
    return {12'ha50, p, l};
  endfunction
  task automatic sel(input logic [1:0] p);
    req(eps_pkg::EPS_CMD_SELECT, {6'h00, p}, 16'h0000);
  endtask
  task automatic burn(input logic [1:0] p, input logic [15:0] d0);
    sel(p);
    for (int l = 0; l < 4; l++)
      req(eps_pkg::EPS_CMD_WRITE, {4'h0, 2'(l), 2'h0},
          l == 0 ? d0 : pat(p, 2'(l)));
    req(eps_pkg::EPS_CMD_PROG, {6'h00, p}, 16'h0000);
    wait_for(0);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_window;
    repeat (T_ACT + 100) @(posedge i_ref_clk);
    req(eps_pkg::EPS_CMD_ACT, 8'h00, 16'h0000);
    mode_is(1'b0);
    do_reset;
    cmp({13'h0, lin_m}, {13'h0, eps_pkg::LIN_OFF});
    req(eps_pkg::EPS_CMD_ACT, 8'h00, 16'h0000);
    mode_is(1'b1);
  endtask
  task automatic t_prog;
    burn(2'h0, 16'h000d);
    cmp({15'h0, st[eps_pkg::ST_OK]}, 16'h0001);
    req(eps_pkg::EPS_CMD_WRITE, 8'h04, 16'hffff);
    sel(2'h0);
    // Burn with no writes: the reload must drop the stray write
    req(eps_pkg::EPS_CMD_PROG, 8'h00, 16'h0000);
    wait_for(0);
    for (int l = 0; l < 4; l++)
      rd(2'(l), l == 0 ? 16'h000d : pat(2'h0, 2'(l)));
    cmp({13'h0, lin_m}, {13'h0, eps_pkg::LIN_VER_D});
    cmp({13'h0, lin_s}, {13'h0, eps_pkg::LIN_EQUAL});
  endtask
  task automatic t_upper;
    burn(2'h2, 16'h1234);
    cmp({15'h0, st[eps_pkg::ST_REFUSE]}, 16'h0001);
    cmp({15'h0, st[eps_pkg::ST_OK]}, 16'h0001);
    sel(2'h2);
    rd(2'h0, 16'h0000);
  endtask
  task automatic t_count;
    for (int i = 0; i < 10; i++)
      burn(2'h1, 16'h0100 + 16'(i));
    cmp({15'h0, ref_seen}, 16'h0000);
    burn(2'h1, 16'h0fff);
    cmp({15'h0, ref_seen}, 16'h0001);
    sel(2'h1);
    rd(2'h0, 16'h0109);
  endtask
  task automatic t_lock;
    req(eps_pkg::EPS_CMD_MARGIN, 8'h03, 16'h0000);
    wait_for(0);
    cmp({15'h0, st[eps_pkg::ST_MARGIN]}, 16'h0001);
    req(eps_pkg::EPS_CMD_LOCK, 8'h00, 16'h0000);
    wait_for(0);
    cmp({15'h0, st[eps_pkg::ST_LOCK]}, 16'h0001);
    req(eps_pkg::EPS_CMD_READ, 8'h80, 16'h0000);
    wait_for(1);
    cmp(o_rd_data, ST_ALL);
    burn(2'h0, 16'hffff);
    sel(2'h0);
    rd(2'h0, 16'h000d);
    cmp({13'h0, lin_m}, {13'h0, eps_pkg::LIN_VER_D});
    req(eps_pkg::EPS_CMD_EXIT, 8'h00, 16'h0000);
    mode_is(1'b0);
  endtask
  initial
  begin
    do_reset;
    t_window;
    t_prog;
    t_upper;
    t_count;
    t_lock;
    end_sim;
  end
endmodule
`default_nettype wire
